/* File: hw/qbp_pkg.sv */
// Package: constants and types for the quasi-bidirectional port latch block
package qbp_pkg;
	localparam int           QBP_NUM_PORTS      = 5;
	localparam int           QBP_PORT_W         = 8;
	localparam int           QBP_SEL_W          = 3;
	localparam logic [7:0]   QBP_LATCH_RST      = 8'hff;
	localparam int           QBP_BOOST_OSC      = 2;
	localparam int           QBP_RST_MCYC       = 2;
	localparam int           QBP_OSC_PER_MCYC   = 12;
	localparam int           QBP_RST_CYC        = QBP_RST_MCYC * QBP_OSC_PER_MCYC;
	localparam logic [2:0]   QBP_PORT0          = 3'h0;
	localparam logic [2:0]   QBP_PORT2          = 3'h2;
	localparam int           QBP_RST_CNT_W      = 6;
	typedef enum logic [1:0] {
		QBP_OP_WRITE,
		QBP_OP_RMW_BYTE,
		QBP_OP_RMW_BIT,
		QBP_OP_NONE
	} qbp_op_t;
endpackage : qbp_pkg

/* File: hw/qbp_core_if.sv */
// Interface: core strobes and data toward the port latches
`timescale 1ns/1ns
`default_nettype none
interface qbp_core_if;
	import qbp_pkg::*;
	logic                  wr_stb;
	logic [QBP_SEL_W-1:0]  wr_port;
	logic [QBP_PORT_W-1:0] wr_data;
	logic [QBP_NUM_PORTS*QBP_PORT_W-1:0] latch_q;
	modport ctl (output wr_stb, output wr_port, output wr_data, input latch_q);
	modport lat (input wr_stb, input wr_port, input wr_data, output latch_q);
endinterface : qbp_core_if
`default_nettype wire

/* File: hw/qbp_latch_bank.sv */
// Module: five port output latches with transition boost pulse
`timescale 1ns/1ns
`default_nettype none
module qbp_latch_bank
	import qbp_pkg::*;
(
	// Clock and reset
	input  wire logic                            sys_clk,
	input  wire logic                            rst,
	input  wire logic                            clk_en,
	// Core side
	qbp_core_if.lat                              core,
	// Boost pulse per bit
	output var  logic [QBP_NUM_PORTS*QBP_PORT_W-1:0] boost
);
	localparam int N = QBP_NUM_PORTS * QBP_PORT_W;
	logic [N-1:0] port_output_latch_ff;
	logic [N-1:0] boost_a_ff;
	logic [N-1:0] boost_b_ff;
	logic [N-1:0] nxt_latch;
	logic [N-1:0] rise;

	// Write strobe loads the selected port latch
	genvar g;
	generate
		for (g = 0; g < QBP_NUM_PORTS; g++) begin : g_port
			assign nxt_latch[g*QBP_PORT_W +: QBP_PORT_W] =
				(core.wr_stb && core.wr_port == QBP_SEL_W'(g)) ? core.wr_data :
				port_output_latch_ff[g*QBP_PORT_W +: QBP_PORT_W];
		end
	endgenerate

	// Zero to one latch change
	assign rise = nxt_latch & ~port_output_latch_ff;

	// Latch storage, all ones at reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port_output_latch_ff <= {QBP_NUM_PORTS{QBP_LATCH_RST}};
			boost_a_ff <= '0;
			boost_b_ff <= '0;
		end else if (clk_en) begin
			port_output_latch_ff <= nxt_latch;
			boost_a_ff <= rise;
			boost_b_ff <= boost_a_ff;
		end
	end

	// Two cycle boost after each rise
	assign boost = boost_a_ff | boost_b_ff;
	assign core.latch_q = port_output_latch_ff;

	AST_BOOST_TWO: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && rise[0]) ##1 clk_en [*2] |-> boost[0])
		else $error("boost pulse short");
endmodule : qbp_latch_bank
`default_nettype wire

/* File: hw/qbp_reset_filter.sv */
// Module: reset pin filter requiring two machine cycles high
`timescale 1ns/1ns
`default_nettype none
module qbp_reset_filter
	import qbp_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	// Synchronised pin level
	input  wire logic pin_hi,
	// Filtered reset
	output var  logic dev_rst
);
	logic [QBP_RST_CNT_W-1:0] cnt_ff;
	logic                     dev_rst_ff;
	logic                     full;
	localparam logic [QBP_RST_CNT_W-1:0] CNT_MAX = QBP_RST_CNT_W'(QBP_RST_CYC - 1);

	assign full = (cnt_ff == CNT_MAX);

	// Count consecutive high oscillator cycles
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_ff     <= '0;
			dev_rst_ff <= 1'b0;
		end else if (clk_en) begin
			if (!pin_hi) begin
				cnt_ff     <= '0;
				dev_rst_ff <= 1'b0;
			end else if (full) begin
				dev_rst_ff <= 1'b1;
			end else begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end
	assign dev_rst = dev_rst_ff;
endmodule : qbp_reset_filter
`default_nettype wire

/* File: hw/qbp_port_top.sv */
// Top: quasi-bidirectional port latch logic for five ports
`timescale 1ns/1ns
`default_nettype none
module qbp_port_top
	import qbp_pkg::*;
(
	// Clock, enable and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 clk_en,
	// Reset pin level
	input  wire logic                 reset_pin,
	output logic                      dev_rst,
	// Core access
	input  wire logic                 op_stb,
	input  wire qbp_op_t              op_kind,
	input  wire logic [QBP_SEL_W-1:0] op_port,
	input  wire logic [2:0]           op_bit,
	input  wire logic                 op_bit_val,
	input  wire logic [7:0]           op_wdata,
	input  wire logic                 rd_latch_stb,
	input  wire logic                 rd_pin_stb,
	input  wire logic [QBP_SEL_W-1:0] rd_port,
	output logic [7:0]                rd_data,
	output logic                      rd_valid,
	// Alternate functions and memory bus
	input  wire logic [39:0]          alt_en,
	input  wire logic [39:0]          alt_out,
	input  wire logic                 mem_cycle,
	input  wire logic [7:0]           bus_addr_data,
	input  wire logic [7:0]           bus_addr_hi,
	// Pins
	input  wire logic [39:0]          pin_in,
	output logic [39:0]               pin_out,
	output logic [39:0]               pin_oe_n,
	output logic [39:0]               pulldown_en,
	output logic [39:0]               strong_pu_en,
	output logic [39:0]               weak_pu_en,
	output logic [39:0]               keeper_pu_en,
	output logic [39:0]               bus_src_sel
);
	localparam int N = QBP_NUM_PORTS * QBP_PORT_W;

	qbp_core_if core();
	logic [N-1:0] boost;
	logic [N-1:0] latch;
	logic [N-1:0] sync1_ff, sync2_ff, sync3_ff, pin_val_ff;
	logic [N-1:0] drive_val, src_sel, pd, spu;
	logic [7:0]   cur_byte, rmw_byte, pin_byte;
	logic [7:0]   rd_data_ff;
	logic         rd_valid_ff;
	logic         rst_req;
	logic         sys_rst;
	logic [N-1:0] pin_out_ff, pin_oe_n_ff, pd_ff, spu_ff, wpu_ff, kpu_ff, sel_ff;

	// Byte select from flat vector
	function automatic logic [7:0] get_byte(input logic [N-1:0] v, input logic [2:0] p);
		get_byte = v[p*QBP_PORT_W +: QBP_PORT_W];
	endfunction : get_byte

	assign sys_rst = rst | dev_rst;
	assign latch   = core.latch_q;

	// Read-modify-write sources the latch, never the pins
	assign cur_byte = get_byte(latch, op_port);
	assign rmw_byte = (op_kind == QBP_OP_RMW_BIT) ?
		((cur_byte & ~(8'h01 << op_bit)) | ({7'h00, op_bit_val} << op_bit)) :
		op_wdata;
	assign core.wr_stb  = op_stb && op_kind != QBP_OP_NONE;
	assign core.wr_port = op_port;
	assign core.wr_data = (op_kind == QBP_OP_WRITE) ? op_wdata : rmw_byte;

	qbp_latch_bank u_bank (
		.sys_clk (sys_clk),
		.rst     (sys_rst),
		.clk_en  (clk_en),
		.core    (core),
		.boost   (boost)
	);

	qbp_reset_filter u_rstf (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.pin_hi  (rst_req),
		.dev_rst (dev_rst)
	);

	// Reset pin synchroniser stages
	logic rsync1_ff, rsync2_ff, rsync3_ff;
	assign rst_req = rsync2_ff & rsync3_ff;
	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			rsync1_ff <= reset_pin;
			rsync2_ff <= rsync1_ff;
			rsync3_ff <= rsync2_ff;
		end
	end

	// Pin synchronisers, change accepted when stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_ff   <= '0;
			sync2_ff   <= '0;
			sync3_ff   <= '0;
			pin_val_ff <= '0;
		end else if (clk_en) begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			pin_val_ff <= (sync2_ff & sync3_ff) | (pin_val_ff & (sync2_ff | sync3_ff));
		end
	end

	// Per-bit source selection and drivers
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_bit
			localparam int PORT = g / QBP_PORT_W;
			localparam int BIT  = g % QBP_PORT_W;
			localparam bit IS_BUS = (PORT == 0) || (PORT == 2);
			assign src_sel[g] = IS_BUS && mem_cycle;
			assign drive_val[g] = src_sel[g] ?
				((PORT == 0) ? bus_addr_data[BIT] : bus_addr_hi[BIT]) :
				(alt_en[g] ? (latch[g] & alt_out[g]) : latch[g]);
			assign pd[g] = ~drive_val[g];
			if (PORT == 0) begin : g_p0
				assign spu[g] = src_sel[g] & drive_val[g];
			end else if (PORT == 2) begin : g_p2
				assign spu[g] = (src_sel[g] & drive_val[g]) | (~src_sel[g] & boost[g]);
			end else begin : g_pq
				assign spu[g] = boost[g];
			end
			// Register drivers one cycle after the latch update
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					pd_ff[g]       <= 1'b0;
					spu_ff[g]      <= 1'b0;
					wpu_ff[g]      <= (PORT != 0);
					kpu_ff[g]      <= 1'b0;
					sel_ff[g]      <= 1'b0;
					pin_out_ff[g]  <= 1'b1;
					pin_oe_n_ff[g] <= 1'b1;
				end else if (clk_en) begin
					pd_ff[g]       <= pd[g];
					spu_ff[g]      <= spu[g];
					sel_ff[g]      <= src_sel[g];
					wpu_ff[g]      <= (PORT != 0) && !pd[g];
					kpu_ff[g]      <= (PORT != 0) && !pd[g] && pin_val_ff[g];
					pin_out_ff[g]  <= drive_val[g];
					pin_oe_n_ff[g] <= !(pd[g] || spu[g] || ((PORT != 0) && !pd[g]));
				end
			end
		end
	endgenerate

	// Read data path
	assign pin_byte = get_byte(pin_val_ff, rd_port);
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_data_ff  <= 8'h00;
			rd_valid_ff <= 1'b0;
		end else if (clk_en) begin
			rd_valid_ff <= rd_latch_stb | rd_pin_stb;
			rd_data_ff  <= rd_latch_stb ? get_byte(latch, rd_port) :
				(rd_pin_stb ? pin_byte : 8'h00);
		end
	end

	assign rd_data      = rd_data_ff;
	assign rd_valid     = rd_valid_ff;
	assign pin_out      = pin_out_ff;
	assign pin_oe_n     = pin_oe_n_ff;
	assign pulldown_en  = pd_ff;
	assign strong_pu_en = spu_ff;
	assign weak_pu_en   = wpu_ff;
	assign keeper_pu_en = kpu_ff;
	assign bus_src_sel  = sel_ff;

	// Timing sequences for latch to pin follow
	sequence s_write_one0;
		clk_en && core.wr_stb && core.wr_port == QBP_PORT0 && !mem_cycle && !alt_en[0]
			&& core.wr_data[0];
	endsequence

	// Zero to one change of port 1 bit 0
	sequence s_rise8;
		clk_en && core.wr_stb && core.wr_port == 3'h1 && core.wr_data[0] && !latch[8];
	endsequence

	// Enabled cycle with no write to port 1
	sequence s_hold8;
		clk_en && !(core.wr_stb && core.wr_port == 3'h1);
	endsequence

	// Reset leaves every latch bit at one
	AST_RST_LATCH: assert property (@(posedge sys_clk)
		sys_rst |=> latch == {QBP_NUM_PORTS{QBP_LATCH_RST}})
		else $error("latch not set by reset");

	// Filtered reset drops once the pin is seen low
	AST_DEV_RST_LOW: assert property (@(posedge sys_clk) disable iff (rst)
		(clk_en && !rst_req) |=> !dev_rst)
		else $error("device reset without pin");

	// Latch read returns the stored byte
	AST_LATCH_READ: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && rd_latch_stb) |=> rd_valid && rd_data == $past(get_byte(latch, rd_port)))
		else $error("latch read wrong");

	// Pin read returns the sampled pins
	AST_PIN_READ: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && rd_pin_stb && !rd_latch_stb) |=> rd_data == $past(pin_byte))
		else $error("pin read wrong");

	// Port 0 has no pull-up outside bus cycles
	AST_P0_OPEN_DRAIN: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sel_ff[0] |-> !spu_ff[0] && !weak_pu_en[0])
		else $error("port 0 pull-up outside bus");

	// Memory cycles move port 2 onto the bus
	AST_BUS_SRC: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && mem_cycle) |=> bus_src_sel[16] && pin_out[16] == $past(bus_addr_hi[0]))
		else $error("port 2 not on bus");

	// Pin drivers follow a latch write one cycle later
	AST_PIN_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_write_one0 ##1 (clk_en && !mem_cycle) |=> !pulldown_en[0])
		else $error("pin did not follow latch");

	// Very weak pull-up on ports 1 to 4 whenever the pull-down is off
	AST_WEAK_PU: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!pulldown_en[8] |-> weak_pu_en[8] || $past(!clk_en))
		else $error("weak pull-up off");

	// Bit modify changes only the addressed bit
	AST_RMW_BIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && op_stb && op_kind == QBP_OP_RMW_BIT)
			|=> get_byte(latch, $past(op_port)) == $past(rmw_byte))
		else $error("bit write wrong");

	// Latch one releases the pull-down
	AST_PULLDOWN: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && !src_sel[8] && !alt_en[8] && latch[8]) |=> !pulldown_en[8])
		else $error("pull-down on with latch one");

	// Ignored request leaves the latches alone
	AST_OP_NONE: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && op_stb && op_kind == QBP_OP_NONE) |=> latch == $past(latch))
		else $error("ignored request changed a latch");

	// Byte modify stores the byte the core computed
	AST_RMW_BYTE: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && op_stb && op_kind == QBP_OP_RMW_BYTE)
			|=> get_byte(latch, $past(op_port)) == $past(op_wdata))
		else $error("byte modify wrong");

	// Boost pulse on a port 1 pin lasts two cycles
	AST_BOOST_ON: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_rise8 ##1 s_hold8 |=> strong_pu_en[8] [*2])
		else $error("boost pulse short");

	// Boost pulse ends after two cycles
	AST_BOOST_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_rise8 ##1 s_hold8 [*3] |=> !strong_pu_en[8])
		else $error("boost pulse long");

	// Keeper pull-up follows the sensed pin level
	AST_KEEPER: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && !pd[12]) |=> keeper_pu_en[12] == $past(pin_val_ff[12]))
		else $error("keeper pull-up wrong");

	// Port 0 strong pull-ups carry bus ones
	AST_P0_BUS_PU: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && mem_cycle) |=> strong_pu_en[7:0] == $past(bus_addr_data))
		else $error("port 0 bus pull-up wrong");

	// Port 2 strong pull-ups carry bus ones
	AST_P2_BUS_PU: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && mem_cycle) |=> strong_pu_en[23:16] == $past(bus_addr_hi))
		else $error("port 2 bus pull-up wrong");

	// Alternate output sets the port 3 pin level
	AST_ALT_OUT: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clk_en && alt_en[24] && latch[24]) |=> pulldown_en[24] == !$past(alt_out[24]))
		else $error("alternate output ignored");
endmodule : qbp_port_top
`default_nettype wire

/* File: testbench/qbp_pin_model.sv */
// Model: port pins with external loads and pull-ups
`timescale 1ns/1ns
`default_nettype none
module qbp_pin_model (
	// Clock
	input  wire logic        sys_clk,
	// Device drivers
	input  wire logic [39:0] pin_out,
	input  wire logic [39:0] pin_oe_n,
	input  wire logic [39:0] pulldown_en,
	input  wire logic [39:0] strong_pu_en,
	// External pull-low per pin
	input  wire logic [39:0] ext_low,
	// Wire level seen by the device
	output logic      [39:0] pin_in
);
	logic float_ff = 1'b0;

	// Changing pattern for undriven open-drain lines
	always @(posedge sys_clk) begin
		float_ff <= ~float_ff;
	end

	// Resolve each wire from all parties
	always_comb begin
		for (int i = 0; i < 40; i++) begin
			if (ext_low[i] || pulldown_en[i] || (!pin_oe_n[i] && !pin_out[i]))
				pin_in[i] = 1'b0;
			else if (strong_pu_en[i] || (!pin_oe_n[i] && pin_out[i]) || i >= 8)
				pin_in[i] = 1'b1; // Ports 1 to 4 have pull-ups, port 0 floats
			else
				pin_in[i] = float_ff;
		end
	end
endmodule : qbp_pin_model
`default_nettype wire

/* File: testbench/testbench.sv */
// Testbench: directed scenarios for the port latch block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
	import qbp_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, reset_pin = 1'b0, op_stb = 1'b0, op_bit_val = 1'b0;
	logic rd_latch_stb = 1'b0, rd_pin_stb = 1'b0, mem_cycle = 1'b0, dev_rst, rd_valid;
	logic clk_en = 1'b1;
	qbp_op_t op_kind = QBP_OP_NONE;
	logic [2:0] op_port = 3'h0, op_bit = 3'h0, rd_port = 3'h0;
	logic [7:0] op_wdata = 8'h00, bus_addr_data = 8'h00, bus_addr_hi = 8'h00, rd_data, v;
	logic [39:0] alt_en = '0, alt_out = '0, ext_low = '0, pin_in, pin_out, pin_oe_n;
	logic [39:0] pulldown_en, strong_pu_en, weak_pu_en, keeper_pu_en, bus_src_sel;
	int bad_count = 0, num_checks = 0, n;

	always #5 sys_clk = ~sys_clk;

	qbp_port_top i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reset_pin(reset_pin),
		.dev_rst(dev_rst), .op_stb(op_stb), .op_kind(op_kind), .op_port(op_port),
		.op_bit(op_bit), .op_bit_val(op_bit_val), .op_wdata(op_wdata),
		.rd_latch_stb(rd_latch_stb), .rd_pin_stb(rd_pin_stb), .rd_port(rd_port),
		.rd_data(rd_data), .rd_valid(rd_valid), .alt_en(alt_en), .alt_out(alt_out),
		.mem_cycle(mem_cycle), .bus_addr_data(bus_addr_data), .bus_addr_hi(bus_addr_hi),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pulldown_en(pulldown_en),
		.strong_pu_en(strong_pu_en), .weak_pu_en(weak_pu_en), .keeper_pu_en(keeper_pu_en),
		.bus_src_sel(bus_src_sel));

	qbp_pin_model i_pins (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pulldown_en(pulldown_en), .strong_pu_en(strong_pu_en), .ext_low(ext_low),
		.pin_in(pin_in));

	// Verdict and end of run
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	// One-cycle write or modify request
	task automatic op(input qbp_op_t k, input logic [2:0] p, input logic [7:0] d,
		input logic [2:0] b, input logic bv);
		@(negedge sys_clk);
		op_stb = 1'b1; op_kind = k; op_port = p; op_wdata = d; op_bit = b; op_bit_val = bv;
		@(negedge sys_clk);
		op_stb = 1'b0;
	endtask : op

	// Latch or pin read, bounded wait for the answer
	task automatic rd(input logic lat, input logic [2:0] p, output logic [7:0] d);
		@(negedge sys_clk);
		rd_latch_stb = lat; rd_pin_stb = ~lat; rd_port = p;
		@(negedge sys_clk);
		rd_latch_stb = 1'b0; rd_pin_stb = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (rd_valid === 1'b1) begin
				d = rd_data;
				return;
			end
			@(negedge sys_clk);
		end
		bad_count++;
		$display("Error rd_valid expected 1 seen 0");
		stop_test();
	endtask : rd

	// Cycles a strong pull-up bit is high over a window
	task automatic hi_cnt(input int idx, output int c);
		c = 0;
		repeat (8) begin
			@(negedge sys_clk);
			if (strong_pu_en[idx] === 1'b1) c++;
		end
	endtask : hi_cnt

	// Reset values of latches and pull-ups
	task automatic t_reset();
		for (int p = 0; p < 5; p++) begin
			rd(1'b1, p[2:0], v);
			`CHK("latch_rst", QBP_LATCH_RST, v)
		end
		`CHK("pulldown_rst", 40'h0, pulldown_en)
		`CHK("p0_float", 8'hff, pin_oe_n[7:0])
		`CHK("weak_pu", 32'hffffffff, weak_pu_en[39:8])
		`CHK("keeper_pu", 32'hffffffff, keeper_pu_en[39:8])
	endtask : t_reset

	// Writes, boost pulse, return to input
	task automatic t_boost();
		op(QBP_OP_WRITE, 3'h1, 8'h00, 3'h0, 1'b0);
		repeat (3) @(negedge sys_clk);
		`CHK("pd_low", 8'hff, pulldown_en[15:8])
		op(QBP_OP_WRITE, 3'h1, 8'h01, 3'h0, 1'b0);
		hi_cnt(8, n);
		`CHK("boost_len", QBP_BOOST_OSC, n)
		`CHK("pd_off", 1'b0, pulldown_en[8])
		`CHK("pd_on", 1'b1, pulldown_en[9])
		rd(1'b1, 3'h1, v);
		`CHK("latch_rd", 8'h01, v)
		op(QBP_OP_WRITE, 3'h1, 8'hff, 3'h0, 1'b0);
		repeat (3) @(negedge sys_clk);
		`CHK("input_again", 8'h00, pulldown_en[15:8])
		op(QBP_OP_WRITE, 3'h0, 8'h00, 3'h0, 1'b0);
		repeat (3) @(negedge sys_clk);
		op(QBP_OP_WRITE, 3'h0, 8'hff, 3'h0, 1'b0);
		hi_cnt(0, n);
		`CHK("p0_no_boost", 0, n)
	endtask : t_boost

	// Bit and byte modify, ignored request
	task automatic t_rmw();
		op(QBP_OP_RMW_BIT, 3'h3, 8'h00, 3'h5, 1'b0);
		repeat (2) @(negedge sys_clk);
		rd(1'b1, 3'h3, v);
		`CHK("rmw_bit", 8'hdf, v)
		op(QBP_OP_RMW_BYTE, 3'h3, 8'h5a, 3'h0, 1'b0);
		op(QBP_OP_NONE, 3'h3, 8'h00, 3'h0, 1'b0);
		repeat (2) @(negedge sys_clk);
		rd(1'b1, 3'h3, v);
		`CHK("rmw_byte", 8'h5a, v)
		op(QBP_OP_WRITE, 3'h3, 8'hff, 3'h0, 1'b0);
	endtask : t_rmw

	// Pin read against latch read
	task automatic t_pin();
		ext_low[12] = 1'b1;
		repeat (8) @(negedge sys_clk);
		rd(1'b0, 3'h1, v);
		`CHK("pin_rd", 8'hef, v)
		rd(1'b1, 3'h1, v);
		`CHK("latch_vs_pin", 8'hff, v)
		`CHK("keeper_off", 1'b0, keeper_pu_en[12])
		ext_low[12] = 1'b0;
	endtask : t_pin

	// Alternate output on a port 3 pin left at one
	task automatic t_alt();
		alt_en[24] = 1'b1;
		repeat (4) @(negedge sys_clk);
		`CHK("alt_low", 1'b1, pulldown_en[24])
		alt_out[24] = 1'b1;
		repeat (4) @(negedge sys_clk);
		`CHK("alt_high", 1'b0, pulldown_en[24])
		alt_en[24] = 1'b0;
	endtask : t_alt

	// Memory cycle drives ports 0 and 2 from the bus
	task automatic t_bus();
		mem_cycle = 1'b1; bus_addr_data = 8'h5a; bus_addr_hi = 8'h3c;
		op(QBP_OP_WRITE, 3'h2, 8'h00, 3'h0, 1'b0);
		repeat (4) @(negedge sys_clk);
		`CHK("src_p0", 8'hff, bus_src_sel[7:0])
		`CHK("src_p2", 8'hff, bus_src_sel[23:16])
		`CHK("src_port1", 8'h00, bus_src_sel[15:8])
		`CHK("p0_oe_bus", 8'h00, pin_oe_n[7:0])
		`CHK("p0_strong", 8'h5a, strong_pu_en[7:0])
		`CHK("p0_bus", 8'h5a, pin_out[7:0])
		`CHK("p2_bus", 8'h3c, pin_out[23:16])
		`CHK("p2_strong", 8'h3c, strong_pu_en[23:16])
		mem_cycle = 1'b0;
		op(QBP_OP_WRITE, 3'h2, 8'hff, 3'h0, 1'b0);
	endtask : t_bus

	// Clock enable low freezes the latches
	task automatic t_freeze();
		@(negedge sys_clk);
		clk_en = 1'b0;
		op(QBP_OP_WRITE, 3'h1, 8'h00, 3'h0, 1'b0);
		clk_en = 1'b1;
		rd(1'b1, 3'h1, v);
		`CHK("frozen", 8'hff, v)
	endtask : t_freeze

	// Reset pin filter, long and short pulses
	task automatic t_devrst();
		op(QBP_OP_WRITE, 3'h4, 8'h00, 3'h0, 1'b0);
		reset_pin = 1'b1;
		repeat (20) @(negedge sys_clk);
		`CHK("dev_rst_early", 1'b0, dev_rst)
		for (int i = 0; i < 20 && dev_rst !== 1'b1; i++) @(negedge sys_clk);
		`CHK("dev_rst_set", 1'b1, dev_rst)
		reset_pin = 1'b0;
		repeat (10) @(negedge sys_clk);
		rd(1'b1, 3'h4, v);
		`CHK("dev_rst_latch", 8'hff, v)
		reset_pin = 1'b1;
		repeat (10) @(negedge sys_clk);
		reset_pin = 1'b0;
		repeat (20) @(negedge sys_clk);
		`CHK("dev_rst_short", 1'b0, dev_rst)
	endtask : t_devrst

	// Main sequence
	initial begin
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		t_reset();
		t_boost();
		t_rmw();
		t_pin();
		t_alt();
		t_bus();
		t_freeze();
		t_devrst();
		stop_test();
	end
endmodule : testbench
`default_nettype wire
